/* File: rtl/cmp_consts.svh */
// Offsets, field positions, reset values and timing counts of the comparator
`ifndef CMP_CONSTS_SVH
`define CMP_CONSTS_SVH
`define CMP_ADDR_W          4
`define CMP_CTRL_ADDR       4'h7
`define CMP_IRQ_STAT_ADDR   4'h8
`define CMP_IRQ_EN_ADDR     4'h9
`define CMP_IRQ_CLR_ADDR    4'ha
`define CMP_STATUS_ADDR     4'hb
`define CMP_CTRL_RESET      8'hff
`define CMP_BIT_RESULT      7
`define CMP_BIT_PIN_EN_N    6
`define CMP_BIT_POL         5
`define CMP_BIT_TCLK_N      4
`define CMP_BIT_POWER       3
`define CMP_BIT_NEG_SEL     2
`define CMP_BIT_POS_SEL     1
`define CMP_BIT_WAKE_EN_N   0
`define CMP_IRQ_WAKE        0
`define CMP_IRQ_EDGE        1
`define CMP_SETTLE_NS       10000
`define CMP_CLK_NS          25
`define CMP_SETTLE_CYC      ((`CMP_SETTLE_NS + `CMP_CLK_NS - 1) / `CMP_CLK_NS)
`endif

/* File: rtl/cmp_pkg.sv */
// Types shared by the comparator control block
package cmp_pkg;
   typedef struct packed
   {
      logic       pin_a_dir_in;
      logic       pin_b_dir_in;
      logic       pin_c_dir_in;
   } port_dir_t;

   typedef struct packed
   {
      logic       pin_a_analog;
      logic       pin_b_analog;
      logic       pin_c_result;
      logic       pin_c_oe;
      logic       pin_c_out;
   } steer_t;

   typedef enum logic [1:0]
   {
      tclk_instr,
      tclk_ext_pin,
      tclk_result
   } tclk_src_t;
endpackage

/* File: rtl/cmp_settle_timer.sv */
// Settling counter restarted on every comparator mode change
`timescale 1ns/1ps
`include "cmp_consts.svh"
module cmp_settle_timer
#(
   parameter int unsigned CYCLES = `CMP_SETTLE_CYC
)
(
   input  wire logic clock,
   input  wire logic reset,
   input  wire logic restart,
   output logic      busy
);
   localparam int W = $clog2(CYCLES + 1);
   logic [W-1:0] count_ff;

   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         count_ff <= W'(CYCLES);
      end
      else if (restart)
      begin
         count_ff <= W'(CYCLES);
      end
      else if (count_ff != '0)
      begin
         count_ff <= count_ff - W'(1);
      end
   end

   assign busy = (count_ff != '0);
endmodule

/* File: rtl/comparator_control.sv */
// Comparator control register, pin steering, timer source and wake logic
// Overview of operation
// - One 8-bit control register at address 07h governs the comparator.
// - Pins a and b are port pins or comparator inputs.
// - Comparator result may drive pin c, replacing its port function.
// - Steering depends on control, option and port direction registers.
// - Polarity bit can invert the result for pin and internal users.
// - Timer clock: instruction, external pin, or comparator result.
// - With the polarity bit set, result is high when positive input exceeds negative input.
// - Wake flag sets when enabled, latched, asleep and result changed.
// - Reset loads all ones; comparator held powered down during reset.
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
`include "cmp_consts.svh"
module comparator_control
#(
   parameter int unsigned SETTLE_CYCLES = `CMP_SETTLE_CYC
)
(
   input  wire logic                     clock,
   input  wire logic                     reset,
   input  wire logic [`CMP_ADDR_W-1:0]   addr,
   input  wire logic [7:0]               wdata,
   input  wire logic                     wr,
   input  wire logic                     rd,
   output logic      [7:0]               rdata,
   output logic                          irq,
   input  wire logic                     analog_above,
   input  wire logic                     external_timer_clock_pin,
   input  wire logic                     instr_cycle,
   input  wire logic                     timer_source_select,
   input  wire cmp_pkg::port_dir_t       port_direction,
   input  wire logic                     asleep,
   input  wire logic                     wake_flag_clear,
   output logic                          compare_wake_flag,
   output logic                          comparator_power_on,
   output logic                          negative_input_select,
   output logic                          positive_input_select,
   output cmp_pkg::steer_t               steer,
   output cmp_pkg::tclk_src_t            timer_src,
   output logic                          timer_clock,
   output logic                          settling
);
   logic [6:0]  ctrl_ff;
   logic        above_s1_ff;
   logic        above_s2_ff;
   logic        tck_s1_ff;
   logic        tck_s2_ff;
   logic        latched_ff;
   logic        latch_valid_ff;
   logic        wake_ff;
   logic [1:0]  stat_ff;
   logic [1:0]  en_ff;
   logic        prev_res_ff;
   logic [7:0]  rdata_ff;
   logic        result;
   logic        ctrl_wr;
   logic        ctrl_rd;
   logic        clr_wr;
   logic        wake_set;
   logic        res_edge;
   logic [7:0]  ctrl_view;

   function automatic logic bit_of(input logic [6:0] r, input int idx);
      return r[idx];
   endfunction

   // Analog comparator output arrives asynchronously
   always_ff @(posedge clock)
   begin
      above_s1_ff <= analog_above;
      above_s2_ff <= above_s1_ff;
      tck_s1_ff   <= external_timer_clock_pin;
      tck_s2_ff   <= tck_s1_ff;
   end

   assign ctrl_wr = wr && addr == `CMP_CTRL_ADDR;
   assign ctrl_rd = rd && addr == `CMP_CTRL_ADDR;
   assign clr_wr  = wr && addr == `CMP_IRQ_CLR_ADDR;

   // Powered-down comparator reads low rather than a floating level
   assign result = comparator_power_on
                 & (above_s2_ff ^ ~bit_of(ctrl_ff, `CMP_BIT_POL));

   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         ctrl_ff <= 7'(`CMP_CTRL_RESET);
      end
      else if (ctrl_wr)
      begin
         ctrl_ff <= wdata[6:0];
      end
   end

   // Held off throughout reset even though the reset value sets the bit
   assign comparator_power_on   = ~reset
                                & bit_of(ctrl_ff, `CMP_BIT_POWER);
   assign negative_input_select = bit_of(ctrl_ff, `CMP_BIT_NEG_SEL);
   assign positive_input_select = bit_of(ctrl_ff, `CMP_BIT_POS_SEL);

   // Pin steering from control, option and direction
   always_comb
   begin
      steer.pin_a_analog = comparator_power_on;
      steer.pin_b_analog = comparator_power_on
                         & bit_of(ctrl_ff, `CMP_BIT_NEG_SEL);
      steer.pin_c_result = comparator_power_on
                         & ~bit_of(ctrl_ff, `CMP_BIT_PIN_EN_N);
      // Result output overrides direction; else a set option bit owns it, a clear one leaves it to direction
      steer.pin_c_oe     = steer.pin_c_result
                         | (~timer_source_select
                            & ~port_direction.pin_c_dir_in);
      steer.pin_c_out    = result;
   end

   // Timer source mux
   always_comb
   begin
      if (!timer_source_select)
      begin
         timer_src   = cmp_pkg::tclk_instr;
         timer_clock = instr_cycle;
      end
      else if (bit_of(ctrl_ff, `CMP_BIT_TCLK_N)
               && bit_of(ctrl_ff, `CMP_BIT_PIN_EN_N))
      begin
         timer_src   = cmp_pkg::tclk_ext_pin;
         timer_clock = tck_s2_ff;
      end
      else
      begin
         timer_src   = cmp_pkg::tclk_result;
         timer_clock = result;
      end
   end

   // Reading the control register latches the result for wake compare
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         latched_ff     <= 1'b0;
         latch_valid_ff <= 1'b0;
      end
      else if (ctrl_rd)
      begin
         latched_ff     <= result;
         latch_valid_ff <= 1'b1;
      end
      else if (ctrl_wr)
      begin
         latch_valid_ff <= 1'b0;
      end
   end

   assign wake_set = ~bit_of(ctrl_ff, `CMP_BIT_WAKE_EN_N) && latch_valid_ff
                   && asleep && (result != latched_ff);

   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         wake_ff <= 1'b0;
      end
      else if (wake_set)
      begin
         wake_ff <= 1'b1;
      end
      else if (wake_flag_clear)
      begin
         wake_ff <= 1'b0;
      end
   end

   assign compare_wake_flag = wake_ff;

   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         prev_res_ff <= 1'b0;
      end
      else
      begin
         prev_res_ff <= result;
      end
   end

   assign res_edge = result ^ prev_res_ff;

   // Sticky status; a new event beats a clear in the same cycle
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         stat_ff <= 2'h0;
      end
      else
      begin
         stat_ff[`CMP_IRQ_WAKE] <= wake_set
            | (stat_ff[`CMP_IRQ_WAKE] & ~(clr_wr & wdata[`CMP_IRQ_WAKE]));
         stat_ff[`CMP_IRQ_EDGE] <= res_edge
            | (stat_ff[`CMP_IRQ_EDGE] & ~(clr_wr & wdata[`CMP_IRQ_EDGE]));
      end
   end

   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         en_ff <= 2'h0;
      end
      else if (wr && addr == `CMP_IRQ_EN_ADDR)
      begin
         en_ff <= wdata[1:0];
      end
   end

   assign irq = |(stat_ff & en_ff);

   cmp_settle_timer
   #(
      .CYCLES (SETTLE_CYCLES)
   )
   u_settle
   (
      .clock   (clock),
      .reset   (reset),
      .restart (ctrl_wr && wdata[6:0] != ctrl_ff),
      .busy    (settling)
   );

   assign ctrl_view = {result, ctrl_ff};

   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         rdata_ff <= 8'h00;
      end
      else if (rd)
      begin
         unique case (addr)
            `CMP_CTRL_ADDR:     rdata_ff <= ctrl_view;
            `CMP_IRQ_STAT_ADDR: rdata_ff <= {6'h00, stat_ff};
            `CMP_IRQ_EN_ADDR:   rdata_ff <= {6'h00, en_ff};
            `CMP_STATUS_ADDR:   rdata_ff <= {6'h00, settling, wake_ff};
            default:            rdata_ff <= 8'h00;
         endcase
      end
      else
      begin
         rdata_ff <= 8'h00;
      end
   end

   assign rdata = rdata_ff;
endmodule

/* File: tb/analog_source.sv */
// Behavioural analog front end: two levels and the raw compare
`timescale 1ns/1ps
module analog_source
(
   input  wire logic [7:0] pos_level,
   input  wire logic [7:0] neg_level,
   output logic            above
);
   // Equal levels read low; real parts are uncertain there
   assign above = pos_level > neg_level;
endmodule

/* File: tb/cmp_checker_properties.sv */
// Port-level assertions for the comparator control block
`timescale 1ns/1ps
module cmp_checker
(
   input wire logic               clock,
   input wire logic               reset,
   input wire logic [3:0]         addr,
   input wire logic [7:0]         wdata,
   input wire logic               wr,
   input wire logic               rd,
   input wire logic [7:0]         rdata,
   input wire logic               timer_source_select,
   input wire logic               instr_cycle,
   input wire cmp_pkg::tclk_src_t timer_src,
   input wire logic               timer_clock,
   input wire logic               comparator_power_on,
   input wire logic               negative_input_select,
   input wire logic               positive_input_select
);
   default clocking @(posedge clock);
   endclocking
   default disable iff (reset);
   sequence ctl_wr;
      wr && addr == 4'h7;
   endsequence
   a_power_reset: assert property (disable iff (1'b0)
      reset |-> !comparator_power_on) else $error("power on in reset");
   a_power_write: assert property (ctl_wr
      |=> comparator_power_on == $past(wdata[3])) else $error("power bit");
   a_select_write: assert property (ctl_wr |=>
      {negative_input_select, positive_input_select} == $past(wdata[2:1]))
      else $error("input selects");
   a_read_idle: assert property (!rd |=> rdata == 8'h00)
      else $error("read data outside read");
   a_read_back: assert property (ctl_wr ##1 !(wr && addr == 4'h7)
      ##1 (rd && addr == 4'h7) |=> rdata[6:0] == $past(wdata[6:0], 3))
      else $error("read back");
   a_src_instr: assert property (!timer_source_select
      |-> timer_src == cmp_pkg::tclk_instr) else $error("source instr");
   a_src_pin: assert property (ctl_wr ##0 (wdata[6] && wdata[4])
      ##1 timer_source_select |-> timer_src == cmp_pkg::tclk_ext_pin)
      else $error("source pin");
   a_src_result: assert property (ctl_wr ##0 !wdata[4]
      ##1 timer_source_select |-> timer_src == cmp_pkg::tclk_result)
      else $error("source result");
   a_clock_mux: assert property (timer_src == cmp_pkg::tclk_instr
      |-> timer_clock == instr_cycle) else $error("timer clock");
endmodule
bind comparator_control cmp_checker chk_inst
(
   .clock                 (clock),
   .reset                 (reset),
   .addr                  (addr),
   .wdata                 (wdata),
   .wr                    (wr),
   .rd                    (rd),
   .rdata                 (rdata),
   .timer_source_select   (timer_source_select),
   .instr_cycle           (instr_cycle),
   .timer_src             (timer_src),
   .timer_clock           (timer_clock),
   .comparator_power_on   (comparator_power_on),
   .negative_input_select (negative_input_select),
   .positive_input_select (positive_input_select)
);

/* File: tb/test_comparator_control.sv */
// Self-checking bench for the comparator control block
`timescale 1ns/1ps
module test_comparator_control;
   typedef struct packed
   {
      logic [7:0]         ctl;
      logic               up;
      logic               tss;
      logic [7:0]         rd_exp;
      cmp_pkg::tclk_src_t src_exp;
   } row_t;
   logic               clock, reset, wr, rd, irq, above, tss;
   logic               asleep, wclr, flag, pwr, instr;
   logic               ext, tclk, settle, ex;
   cmp_pkg::port_dir_t dir;
   logic [3:0]         addr;
   logic [7:0]         wdata, rdata, d, pos_level;
   cmp_pkg::steer_t    steer;
   cmp_pkg::tclk_src_t src;
   int                 n_errors, check_count;
   row_t               rows [5] = '{
      '{8'h28, 1'b1, 1'b1, 8'ha8, cmp_pkg::tclk_result},
      '{8'h08, 1'b1, 1'b0, 8'h08, cmp_pkg::tclk_instr},
      '{8'h08, 1'b0, 1'b1, 8'h88, cmp_pkg::tclk_result},
      '{8'hf7, 1'b0, 1'b1, 8'h77, cmp_pkg::tclk_ext_pin},
      '{8'h58, 1'b0, 1'b1, 8'hd8, cmp_pkg::tclk_ext_pin}};
   comparator_control #(.SETTLE_CYCLES(4)) i_comparator_control
   (
      .clock(clock), .reset(reset), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .analog_above(above),
      .external_timer_clock_pin(ext), .instr_cycle(instr),
      .timer_source_select(tss), .port_direction(dir),
      .asleep(asleep), .wake_flag_clear(wclr), .compare_wake_flag(flag),
      .comparator_power_on(pwr), .negative_input_select(),
      .positive_input_select(), .steer(steer), .timer_src(src),
      .timer_clock(tclk), .settling(settle)
   );
   analog_source p_src
   (
      .pos_level(pos_level), .neg_level(8'h80), .above(above)
   );
   initial
   begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   always @(posedge clock) instr <= ~instr;
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wreg(input logic [3:0] a, input logic [7:0] v);
      @(posedge clock);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
   endtask
   // Data stand one cycle; taken at the edge that ends it
   task automatic rreg(input logic [3:0] a);
      @(posedge clock);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      @(posedge clock);
      d = rdata;
   endtask
   task automatic close_out;
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial
   begin
      #50000;
      n_errors++;
      close_out;
   end
   initial
   begin
      {reset, instr, pos_level} = {1'b1, 1'b0, 8'h70};
      {wr, rd, addr, wdata, tss, asleep, wclr, dir} = '0;
      ext = 1'b1;
      repeat (4) @(posedge clock);
      chk(pwr, 1'b0);
      reset <= 1'b0;
      rreg(4'h7);
      chk(d, 8'h7f);
      rreg(4'hc);
      chk(d, 8'h00);
      foreach (rows[i])
      begin
         pos_level <= rows[i].up ? 8'h90 : 8'h70;
         tss <= rows[i].tss;
         wreg(4'h7, rows[i].ctl);
         // Settling count of 4 plus two sync stages
         repeat (8) @(posedge clock);
         rreg(4'h7);
         chk(d, rows[i].rd_exp);
         chk(8'(src), 8'(rows[i].src_exp));
         chk(steer.pin_c_result, !rows[i].ctl[6]);
         chk(steer.pin_c_out, rows[i].rd_exp[7]);
         chk(steer.pin_a_analog, rows[i].ctl[3]);
         ex = (rows[i].ctl[3] & !rows[i].ctl[6]) | !rows[i].tss;
         chk(steer.pin_c_oe, ex);
         ex = rows[i].src_exp == cmp_pkg::tclk_result ? rows[i].rd_exp[7]
            : rows[i].src_exp == cmp_pkg::tclk_ext_pin ? ext : instr;
         chk(tclk, ex);
      end
      // Result pin off, option bit clear: direction owns pin c
      tss <= 1'b0;
      dir <= 3'b001;
      @(posedge clock);
      chk(steer.pin_c_oe, 1'b0);
      dir <= 3'b000;
      @(posedge clock);
      chk(steer.pin_c_oe, 1'b1);
      wreg(4'h7, 8'h2e);
      rreg(4'hb);
      chk(d, 8'h02);
      chk(settle, 1'b1);
      rreg(4'h7);
      chk({1'b0, d[6:0]}, 8'h2e);
      wreg(4'h9, 8'h01);
      repeat (8) @(posedge clock);
      chk(settle, 1'b0);
      rreg(4'h7);
      pos_level <= 8'h90;
      repeat (6) @(posedge clock);
      chk(flag, 1'b0);
      chk(irq, 1'b0);
      pos_level <= 8'h70;
      repeat (4) @(posedge clock);
      asleep <= 1'b1;
      pos_level <= 8'h90;
      repeat (6) @(posedge clock);
      chk(flag, 1'b1);
      chk(irq, 1'b1);
      rreg(4'h8);
      chk(d, 8'h03);
      // Leave sleep first, or the status would set again at once
      asleep <= 1'b0;
      wreg(4'ha, 8'h03);
      rreg(4'h8);
      chk(d, 8'h00);
      chk(irq, 1'b0);
      chk(flag, 1'b1);
      wclr <= 1'b1;
      @(posedge clock);
      wclr <= 1'b0;
      @(posedge clock);
      chk(flag, 1'b0);
      reset <= 1'b1;
      repeat (2) @(posedge clock);
      chk(pwr, 1'b0);
      reset <= 1'b0;
      rreg(4'h7);
      chk(d, 8'hff);
      close_out;
   end
endmodule
